// File: design/legacy_driver_defines.vh
// constants for the legacy driver support block
// Notes on behaviour
// R1: driver flags copied into status bits 24..31
// R2: send current only when coarse five bits or resolution change
// R3: resolution change matters only below four
// R4: fullstep current at or above threshold velocity
// R5: fullstep status high while enabled and active
// R6: mixed decay from two-bit setting
// R7: decay bits use setting and table values
// R8: undivided clock on standby pin after reset
// R9: pin setting 10 outputs divided clock
// R10: host keeps chopper clock below 50 kHz
// R11: load bits read as unsigned 0..7
// R12: stall when load at or below limit
// R13: stall above velocity limit forces velocity zero
// R14: standby on stall zeroes currents, sends standby
// R15: host sets drive-after-stall to release ramp
// R16: stall bit may replace status bit 24
// R17: format 1010 selects next family SPI mode
// R18: host selects family with format 1000/1001
// R19: masked driver flags ORed into event 30
// R20: compares evaluated every clock cycle
`ifndef LEGACY_DRIVER_DEFINES_VH
`define LEGACY_DRIVER_DEFINES_VH
// ----------------------------------------------------------------
// register indices
// ----------------------------------------------------------------
`define REG_GENERAL_CONFIG   7'h00
`define REG_REFERENCE_CONFIG 7'h01
`define REG_DRIVER_LINK      7'h04
`define REG_STEP_CONFIG      7'h0A
`define REG_STATUS_WORD      7'h0F
`define REG_CHOP_DIV         7'h1F
`define REG_FULLSTEP_THRESHOLD_VELOCITY           7'h60
`define REG_STALL_VEL        7'h67
`define REG_COIL_OUT         7'h7B
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FULLSTEP_ENABLE_BIT  19
`define PIN_ASSIGN_HI        14
`define PIN_ASSIGN_LO        13
`define PIN_ASSIGN_DIVCLK    2'h2
`define STOP_ON_STALL_BIT    26
`define DRIVE_AFTER_BIT      27
`define FORMAT_HI            3
`define FORMAT_LO            0
`define FORMAT_FAMILY_A      4'h8
`define FORMAT_FAMILY_B      4'h9
`define FORMAT_NEXT_SPI      4'hA
`define COVER_LEN_HI         19
`define COVER_LEN_LO         13
`define STANDBY_ON_STALL_BIT 6
`define STALL_REPLACE_BIT    7
`define LOAD_LIMIT_HI        10
`define LOAD_LIMIT_LO        8
`define DECAY_HI             12
`define DECAY_LO             11
`define EVENT_MASK_HI        23
`define EVENT_MASK_LO        16
`define STATUS_FLAGS_LO      24
`define STATUS_FS_BIT        15
`define STATUS_STALL_BIT     11
`define DECAY_NEVER          2'h0
`define DECAY_FALLING        2'h1
`define DECAY_MOVING         2'h2
`define DECAY_ALWAYS         2'h3
`define RES_COARSE_LIMIT     4'h4
`define STANDBY_WORD         12'h000
`define FS_CURRENT_MAG       4'hB
`endif

// File: design/chopper_clock_gen.v
// divided chopper clock for the standby/clock pin
`timescale 1ns/1ns
module chopper_clock_gen #(
	parameter DIV_W = 32
) (
	input  wire             clk_sys,
	input  wire             arst_n,
	input  wire [DIV_W-1:0] divider,
	output reg              divClk_r
);
	reg [DIV_W-1:0] count_r;
	wire [DIV_W-1:0] half;
	assign half = {1'b0, divider[DIV_W-1:1]};
	// toggle at half period; divider below 2 gives a stopped low clock
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			count_r  <= {DIV_W{1'b0}};
			divClk_r <= 1'b0;
		end else if (divider < 2) begin
			count_r  <= {DIV_W{1'b0}};
			divClk_r <= 1'b0;
		end else if (count_r >= divider - 1'b1) begin
			count_r  <= {DIV_W{1'b0}};
			divClk_r <= 1'b0;
		end else begin
			count_r  <= count_r + 1'b1;
			if (count_r == half - 1'b1)
				divClk_r <= 1'b1; // R9
		end
	end
endmodule

// File: design/legacy_driver_spi_support.v
// support logic for the older SPI stepper driver family
`timescale 1ns/1ns
`include "legacy_driver_defines.vh"
module legacy_driver_spi_support #(
	parameter VEL_W = 32
) (
	input  wire             clk_sys,
	input  wire             arst_n,
	input  wire             regWrite,
	input  wire [6:0]       regAddr,
	input  wire [31:0]      regWdata,
	output reg  [31:0]      regRdata,
	input  wire [VEL_W-1:0] rampVelIn,
	input  wire [8:0]       tableA,
	input  wire [8:0]       tableB,
	input  wire [3:0]       stepResolution,
	input  wire             respValid,
	input  wire [7:0]       respFlags,
	input  wire [2:0]       respLoad,
	input  wire             standstill,
	input  wire             datagramReady,
	output wire [VEL_W-1:0] rampVelOut,
	output reg              datagramValid_r,
	output reg  [11:0]      datagramWord_r,
	output wire             standbyClk,
	output wire             driverEvent,
	output wire             velocityBlocked,
	output wire             nextFamilySpi
);
	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	reg  [31:0] generalCfg_r;
	reg  [31:0] referenceCfg_r;
	reg  [31:0] linkCfg_r;
	reg  [31:0] stepCfg_r;
	reg  [31:0] chopDiv_r;
	reg  [31:0] fsVel_r;
	reg  [31:0] stallVel_r;
	reg  [7:0]  flags_r;
	reg  [2:0]  load_r;
	reg  [4:0]  lastA_r;
	reg  [4:0]  lastB_r;
	reg  [3:0]  lastRes_r;
	reg         halted_r;
	reg         standbyPend_r;
	reg  [17:0] coilOut_r;
	wire        divClk;

	// register writes; only whole words, no byte lanes on this port
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			generalCfg_r   <= 32'h0000_0000;
			referenceCfg_r <= 32'h0000_0000;
			linkCfg_r      <= 32'h0000_0000;
			stepCfg_r      <= 32'h0000_0000;
			chopDiv_r      <= 32'h0000_0000;
			fsVel_r        <= 32'h0000_0000;
			stallVel_r     <= 32'h0000_0000;
		end else if (regWrite) begin
			case (regAddr)
				`REG_GENERAL_CONFIG:   generalCfg_r   <= regWdata;
				`REG_REFERENCE_CONFIG: referenceCfg_r <= regWdata;
				`REG_DRIVER_LINK:      linkCfg_r      <= regWdata;
				`REG_STEP_CONFIG:      stepCfg_r      <= regWdata;
				`REG_CHOP_DIV:         chopDiv_r      <= regWdata;
				`REG_FULLSTEP_THRESHOLD_VELOCITY:           fsVel_r        <= regWdata;
				`REG_STALL_VEL:        stallVel_r     <= regWdata;
				default:               ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// decoded fields
	// ----------------------------------------------------------------
	wire [3:0] format    = linkCfg_r[`FORMAT_HI:`FORMAT_LO];
	wire       coverZero = (linkCfg_r[`COVER_LEN_HI:`COVER_LEN_LO] == 7'h00);
	wire       familySel = coverZero &&
		((format == `FORMAT_FAMILY_A) || (format == `FORMAT_FAMILY_B));
	assign nextFamilySpi = coverZero && (format == `FORMAT_NEXT_SPI); // R17
	wire [1:0] decayMode = linkCfg_r[`DECAY_HI:`DECAY_LO];
	wire [2:0] loadLimit = linkCfg_r[`LOAD_LIMIT_HI:`LOAD_LIMIT_LO];

	// absolute value of a two's complement velocity
	function [VEL_W-1:0] absVel;
		input [VEL_W-1:0] v;
		begin
			absVel = v[VEL_W-1] ? (~v + 1'b1) : v;
		end
	endfunction

	// ----------------------------------------------------------------
	// response capture; the link side runs on clk_sys, so no synchroniser is needed
	// ----------------------------------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= 8'h00;
			load_r  <= 3'h0;
		end else if (respValid) begin
			flags_r <= respFlags; // R1
			load_r  <= respLoad;  // R11
		end
	end

	// ----------------------------------------------------------------
	// stall and fullstep compares, combinational every cycle
	// ----------------------------------------------------------------
	wire [VEL_W-1:0] velAbs = absVel(rampVelIn);
	wire stallBit  = (load_r <= loadLimit); // R12 R20
	wire stallFast = stallBit && (velAbs > stallVel_r[VEL_W-1:0]);
	wire stopArmed = referenceCfg_r[`STOP_ON_STALL_BIT] && !referenceCfg_r[`DRIVE_AFTER_BIT];
	wire fsActive  = generalCfg_r[`FULLSTEP_ENABLE_BIT] &&
		(velAbs >= fsVel_r[VEL_W-1:0]); // R4 R20

	// halt latches until the host sets drive-after-stall
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n)
			halted_r <= 1'b0;
		else if (referenceCfg_r[`DRIVE_AFTER_BIT])
			halted_r <= 1'b0; // R15
		else if (stopArmed && stallFast)
			halted_r <= 1'b1; // R13
	end
	wire stopNow = stopArmed && stallFast;
	// drive-after-stall frees the ramp at once, not one edge after halted_r clears
	assign velocityBlocked = (halted_r && !referenceCfg_r[`DRIVE_AFTER_BIT]) || stopNow; // R15
	assign rampVelOut = velocityBlocked ? {VEL_W{1'b0}} : rampVelIn; // R13

	// ----------------------------------------------------------------
	// status word and driver event
	// ----------------------------------------------------------------
	wire [7:0] statusFlags = {flags_r[7:1],
		linkCfg_r[`STALL_REPLACE_BIT] ? stallBit : flags_r[0]}; // R16
	wire [31:0] statusWord = {statusFlags, 8'h00, fsActive, 3'h0,
		stallFast, 11'h000}; // R1 R5
	assign driverEvent = |(flags_r & stepCfg_r[`EVENT_MASK_HI:`EVENT_MASK_LO]); // R19

	// ----------------------------------------------------------------
	// current datagram build
	// ----------------------------------------------------------------
	// decay bit for one coil from its table value and the mode
	function decayBit;
		input [1:0] mode;
		input [8:0] now;
		input [4:0] prev;
		input       still;
		begin
			case (mode)
				`DECAY_NEVER:   decayBit = 1'b0;
				`DECAY_FALLING: decayBit = (now[7:4] < prev[3:0]) && (now[7:4] != 4'h0);
				`DECAY_MOVING:  decayBit = !still;
				default:        decayBit = 1'b1;
			endcase
		end
	endfunction

	// coarse sign plus magnitude, fullstep forces the fixed magnitude
	wire [4:0] coarseA = fsActive ? {tableA[8], `FS_CURRENT_MAG} : tableA[8:4];
	wire [4:0] coarseB = fsActive ? {tableB[8], `FS_CURRENT_MAG} : tableB[8:4];
	wire resChange = (stepResolution != lastRes_r) &&
		(stepResolution < `RES_COARSE_LIMIT); // R3
	wire coarseChange = (coarseA != lastA_r) || (coarseB != lastB_r); // R2
	wire mdA = decayBit(decayMode, tableA, lastA_r, standstill); // R6 R7
	wire mdB = decayBit(decayMode, tableB, lastB_r, standstill); // R6 R7
	wire haltStandby = stopNow && !halted_r && linkCfg_r[`STANDBY_ON_STALL_BIT];

	// pending standby survives a busy link; it has priority over current data
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			datagramValid_r <= 1'b0;
			datagramWord_r  <= 12'h000;
			lastA_r         <= 5'h00;
			lastB_r         <= 5'h00;
			lastRes_r       <= 4'h0;
			standbyPend_r   <= 1'b0;
			coilOut_r       <= 18'h00000;
		end else begin
			if (datagramValid_r && datagramReady)
				datagramValid_r <= 1'b0;
			if (haltStandby)
				standbyPend_r <= 1'b1;
			if (!datagramValid_r || datagramReady) begin
				if (familySel && (standbyPend_r || haltStandby)) begin
					datagramValid_r <= 1'b1;
					datagramWord_r  <= `STANDBY_WORD; // R14
					coilOut_r       <= 18'h00000;      // R14
					lastA_r         <= 5'h00;
					lastB_r         <= 5'h00;
					standbyPend_r   <= 1'b0;
				end else if (familySel && !velocityBlocked && (coarseChange || resChange)) begin
					datagramValid_r <= 1'b1;
					datagramWord_r  <= {mdA, coarseA, mdB, coarseB}; // R2 R7
					coilOut_r       <= {tableB, tableA};
					lastA_r         <= coarseA;
					lastB_r         <= coarseB;
					lastRes_r       <= stepResolution;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// standby/clock pin
	// ----------------------------------------------------------------
	chopper_clock_gen #(
		.DIV_W (32)
	) u_chop (
		.clk_sys  (clk_sys),
		.arst_n   (arst_n),
		.divider  (chopDiv_r),
		.divClk_r (divClk)
	);
	// after reset the pin carries the raw system clock
	assign standbyClk = (generalCfg_r[`PIN_ASSIGN_HI:`PIN_ASSIGN_LO] == `PIN_ASSIGN_DIVCLK)
		? divClk : clk_sys; // R8 R9

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always @* begin
		case (regAddr)
			`REG_GENERAL_CONFIG:   regRdata = generalCfg_r;
			`REG_REFERENCE_CONFIG: regRdata = referenceCfg_r;
			`REG_DRIVER_LINK:      regRdata = linkCfg_r;
			`REG_STEP_CONFIG:      regRdata = stepCfg_r;
			`REG_STATUS_WORD:      regRdata = statusWord;
			`REG_CHOP_DIV:         regRdata = chopDiv_r;
			`REG_FULLSTEP_THRESHOLD_VELOCITY:           regRdata = fsVel_r;
			`REG_STALL_VEL:        regRdata = stallVel_r;
			`REG_COIL_OUT:         regRdata = {7'h00, coilOut_r[17:9], 7'h00, coilOut_r[8:0]};
			default:               regRdata = 32'h0000_0000;
		endcase
	end
endmodule

// File: dv/legacy_driver_asserts.sv
// assertion checker for the legacy driver support block
`timescale 1ns/1ns
module legacy_driver_asserts #(
	parameter VEL_W = 32
) (
	input wire             clk_sys,
	input wire             arst_n,
	input wire             regWrite,
	input wire [6:0]       regAddr,
	input wire [31:0]      regWdata,
	input wire [31:0]      regRdata,
	input wire [VEL_W-1:0] rampVelIn,
	input wire             respValid,
	input wire [7:0]       respFlags,
	input wire [2:0]       respLoad,
	input wire             datagramReady,
	input wire [VEL_W-1:0] rampVelOut,
	input wire             datagramValid_r,
	input wire [11:0]      datagramWord_r,
	input wire             driverEvent,
	input wire             velocityBlocked,
	input wire             nextFamilySpi
);
	reg  [31:0]      shadow_r [0:127];
	reg  [7:0]       flags_r;
	reg  [2:0]       load_r;
	integer          i;
	wire [31:0]      link = shadow_r[4];
	wire [31:0]      refc = shadow_r[1];
	wire [VEL_W-1:0] absVel = rampVelIn[VEL_W-1] ? -rampVelIn : rampVelIn;
	wire             stall = load_r <= link[10:8];
	wire             famSel = link[3:1] == 3'h4 && link[19:13] == 7'h00;
	// shadow copies follow writes and responses at the design's own edge
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			for (i = 0; i < 128; i = i + 1)
				shadow_r[i] <= 32'h0;
			flags_r <= 8'h00;
			load_r <= 3'h0;
		end else begin
			if (regWrite)
				shadow_r[regAddr] <= regWdata;
			if (respValid)
				flags_r <= respFlags;
			if (respValid)
				load_r <= respLoad;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	sequence respThenRead;
		respValid ##1 regAddr == 7'h0F;
	endsequence
	chk_flags_copied: assert property (respThenRead |-> regRdata[31:25] == flags_r[7:1])
		else $error("status flags differ from response");
	chk_stall_flag: assert property (regAddr == 7'h0F && link[7] && !$past(respValid)
		&& !$past(regWrite) |-> regRdata[24] == stall) else $error("stall flag wrong");
	chk_vel_zeroed: assert property (rampVelOut == (velocityBlocked ? 0 : rampVelIn))
		else $error("velocity output wrong");
	chk_stop_stall: assert property (refc[26] && !refc[27] && stall && absVel > shadow_r[103]
		|-> velocityBlocked) else $error("stall did not halt");
	chk_halt_release: assert property (refc[27] |-> !velocityBlocked)
		else $error("halt not released");
	chk_word_holds: assert property (datagramValid_r && !datagramReady
		|=> datagramValid_r && $stable(datagramWord_r)) else $error("datagram dropped");
	chk_no_family: assert property (!famSel && !datagramValid_r |=> !datagramValid_r)
		else $error("datagram without family");
	chk_event_or: assert property (driverEvent == |(flags_r & shadow_r[10][23:16]))
		else $error("event wrong");
	chk_next_spi: assert property (nextFamilySpi == (link[3:0] == 4'hA && link[19:13] == 0))
		else $error("next family flag wrong");
endmodule
bind legacy_driver_spi_support legacy_driver_asserts #(.VEL_W(VEL_W)) chk (.*);

// File: dv/driver_partner_model.sv
// behavioural model of the older SPI power driver
`timescale 1ns/1ns
module driver_partner_model (
	input  wire        clk_sys,
	input  wire        arst_n,
	input  wire        datagramValid_r,
	input  wire [11:0] datagramWord_r,
	input  wire [7:0]  setFlags,
	input  wire [2:0]  setLoad,
	input  wire        slowMode,
	output reg         datagramReady,
	output reg         respValid,
	output reg  [7:0]  respFlags,
	output reg  [2:0]  respLoad,
	output reg  [11:0] lastWord_r
);
	wire take = datagramValid_r && datagramReady;
	// answers each taken datagram next cycle; data lines churn otherwise
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			{datagramReady, respValid, respFlags, respLoad, lastWord_r} <= 0;
		end else begin
			datagramReady <= slowMode ? !datagramReady : 1'b1;
			respValid <= take;
			respFlags <= take ? setFlags : ~respFlags;
			respLoad <= take ? setLoad : ~respLoad;
			if (take)
				lastWord_r <= datagramWord_r;
		end
	end
endmodule

// File: dv/test_legacy_driver_spi_support.sv
// self-checking bench for the legacy driver support block
`timescale 1ns/1ns
module test_legacy_driver_spi_support;
	localparam [34:0] DEC = {5'h1D, 5'h14, 5'h0B, 5'h19, 5'h11, 5'h08, 5'h00};
	reg  [31:0] rampVelIn = 0, regWdata = 0;
	reg  [6:0]  regAddr = 0;
	reg  [8:0]  tableA = 9'h020, tableB = 9'h020, d;
	reg  [7:0]  setFlags = 0;
	reg  [4:0]  c;
	reg  [2:0]  setLoad = 0;
	reg  [3:0]  stepResolution = 4'h8;
	reg         clk_sys = 0, arst_n = 0, regWrite = 0, standstill = 0, slowMode = 0, got;
	wire [31:0] regRdata, rampVelOut;
	wire [11:0] datagramWord_r, lastWord_r;
	wire [7:0]  respFlags;
	wire [2:0]  respLoad;
	wire        datagramValid_r, datagramReady, respValid, standbyClk;
	wire        driverEvent, velocityBlocked, nextFamilySpi;
	integer     fails = 0, cmp_count = 0, i, n;
	always #50 clk_sys = ~clk_sys;
	legacy_driver_spi_support uut (.*);
	driver_partner_model drv (.*);
	// ----
	// access and compare tasks
	// ----
	task chk(input string nm, input [31:0] seen, exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task step(input integer k);
		repeat (k) @(posedge clk_sys) #10;
	endtask
	// extra idle cycles let any datagram caused by the write finish first
	task wr(input [6:0] a, input [31:0] v);
		{regWrite, regAddr, regWdata} = {1'b1, a, v};
		step(1);
		regWrite = 1'b0;
		step(3);
	endtask
	task rd(input string nm, input [6:0] a, input [31:0] m, e);
		regAddr = a;
		step(2);
		chk(nm, regRdata & m, e);
	endtask
	task mv(input [8:0] a, b);
		{tableA, tableB} = {a, b};
		got = 1'b0;
		for (n = 0; n < 20 && !got; n = n + 1) begin
			step(1);
			got = respValid;
		end
		if (!got) begin
			fails = fails + 1;
			stop_test;
		end
	endtask
	task resp(input [7:0] f, input [2:0] l);
		{setFlags, setLoad} = {f, l};
		mv(tableA ^ 9'h010, tableB);
		step(1);
	endtask
	// ----
	// scenarios
	// ----
	initial begin
		step(10);
		arst_n = 1'b1;
		step(1);
		chk("clkHigh", standbyClk, 1);
		#50 chk("clkLow", standbyClk, 0);
		#50 wr(7'h1F, 4);
		wr(7'h00, 32'h4000);
		{got, n} = {standbyClk, 0};
		for (i = 0; i < 40; i = i + 1) begin
			step(1);
			n = n + (standbyClk && !got);
			got = standbyClk;
		end
		chk("divClk", n, 10);
		rd("divider", 7'h1F, 32'hFFFFFFFF, 4);
		wr(7'h04, 32'h8);
		slowMode = 1'b1;
		for (i = 0; i < 8; i = i + 1) begin
			resp(8'h01 << i, 3'h7);
			rd("flags", 7'h0F, 32'hFF000000, 32'h01000000 << i);
		end
		slowMode = 1'b0;
		for (i = 0; i < 7; i = i + 1) begin
			c = DEC[5*i +: 5];
			standstill = c[2];
			wr(7'h04, {19'h0, c[4:3], 11'h008});
			d = c[1] ? 9'h1F0 : 9'h010;
			mv(tableA + d, tableB + d);
			chk("decay", lastWord_r, {c[0], tableA[8:4], c[0], tableB[8:4]});
		end
		stepResolution = 4'h2;
		mv(tableA, tableB);
		chk("resChange", lastWord_r[10:6], tableA[8:4]);
		tableA = tableA + 9'h001;
		got = 1'b0;
		for (i = 0; i < 20; i = i + 1) begin
			step(1);
			got = got | respValid;
		end
		chk("lowBits", got, 0);
		wr(7'h60, 100);
		wr(7'h00, 32'h80000);
		for (i = 0; i < 4; i = i + 1) begin
			rampVelIn = (i[0] ? 99 : 100) * (i[1] ? -1 : 1);
			rd("fullstep", 7'h0F, 32'h8000, i[0] ? 0 : 32'h8000);
		end
		wr(7'h00, 0);
		rd("fsOff", 7'h0F, 32'h8000, 0);
		wr(7'h04, 32'h388);
		for (i = 0; i < 4; i = i + 1) begin
			resp({7'h0, i[1]}, 3'h3 + (i[0] ^ i[1]));
			rd("stallBit", 7'h0F, 32'hFF000000, {7'h0, !(i[0] ^ i[1]), 24'h0});
		end
		rampVelIn = 0;
		wr(7'h67, 50);
		wr(7'h04, 32'h348);
		wr(7'h01, 32'h04000000);
		rampVelIn = 60;
		step(8);
		chk("halted", rampVelOut, 0);
		chk("standby", lastWord_r, 12'h000);
		rampVelIn = 40;
		step(2);
		chk("stillHalted", rampVelOut, 0);
		wr(7'h01, 32'h0C000000);
		chk("released", rampVelOut, 40);
		wr(7'h04, 32'hA);
		chk("nextSpi", nextFamilySpi, 1);
		wr(7'h04, 32'h200A);
		chk("nextOff", nextFamilySpi, 0);
		wr(7'h04, 32'h8);
		wr(7'h0A, 32'h00040000);
		resp(8'h04, 3'h7);
		chk("eventOn", driverEvent, 1);
		resp(8'h08, 3'h7);
		chk("eventOff", driverEvent, 0);
		rd("unmapped", 7'h02, 32'hFFFFFFFF, 0);
		stop_test;
	end
endmodule
